//--- rtl/epc_config.sv
`timescale 1ns/1ps
`include "epc_defs.svh"
// Functional notes
// [R1] soft reset bit 0 restores defaults, floats
// [R2] bit 1 low stops booster, keeps registers
// [R3] bit 2 chooses source shift direction
// [R4] bit 3 chooses gate scan direction
// [R5] bit 5 chooses power switch timing
// [R6] bits 7-6 choose display resolution
// [R7] float electrode after refresh option
// [R8] ground electrode before power off option
// [R9] tie negative gate supply at off
// [R10] choose automatic temperature measurement moment
// [R11] keep electrode always floating option
// [R12] extra frame or source hi-z option
// [R13] waveform table source select
// [R14] electrode option priority order
// [R15] internal or external supply selects
// [R16] source power switching mode
// [R17] symmetric gate voltage level code
// [R18] positive source codes saturate at 78h
// [R19] negative source code, 7 bits
// [R20] serial port is always slave
// [R21] device samples on rising clock edge
// [R22] command byte then ordered parameters
// [R23] registers take defaults after reset
module epc_config (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               rst_n_pin_i,
  input  wire logic               sclk_i,
  input  wire logic               csb_n_i,
  input  wire logic               cmd_data_select_i,
  input  wire logic               sdata_i,
  output logic                    sdata_o,
  output logic                    sdata_oe_o,
  output epc_pkg::epc_panel_t     panel_o,
  output epc_pkg::epc_power_t     power_o,
  output epc_pkg::epc_com_t       com_mode_o,
  output logic                    float_outputs_o,
  output logic                    temp_measure_o,
  output logic                    byte_valid_o
);
  logic [2:0] sclk_s, csb_s, dc_s, sd_s;
  logic [1:0] rstp_s;
  logic [7:0] shift;
  logic [2:0] bit_cnt;
  logic [7:0] panel1, panel2;
  logic [7:0] supply_source_select [0:5];
  logic [2:0] param_idx;
  logic       floated;
  logic       rstp_q;
  logic       boost_q;
  epc_pkg::epc_state_t state;
  epc_pkg::epc_panel_t next_panel;
  epc_pkg::epc_power_t next_power;
  epc_pkg::epc_com_t   next_com;

  // two-flop synchronisers; only stage 2 and later are read
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sclk_s <= 3'h0;
      csb_s  <= 3'h7;
      dc_s   <= 3'h0;
      sd_s   <= 3'h0;
      rstp_s <= 2'h0;
    end
    else
    begin
      sclk_s <= {sclk_s[1:0], sclk_i};
      csb_s  <= {csb_s[1:0], csb_n_i};
      dc_s   <= {dc_s[1:0], cmd_data_select_i};
      sd_s   <= {sd_s[1:0], sdata_i};
      rstp_s <= {rstp_s[0], rst_n_pin_i};
    end
  end
  wire sclk_rise = sclk_s[1] & ~sclk_s[2];
  wire selected  = ~csb_s[1];
  wire byte_done = selected & sclk_rise & (bit_cnt == 3'h7);
  wire [7:0] byte_in = {shift[6:0], sd_s[1]};
  wire is_cmd    = ~dc_s[1];
  wire pin_reset = ~rstp_s[1];
  wire pin_rise  = rstp_s[1] & ~rstp_q;
  // write to panel byte 1 with bit 0 low acts as a soft reset
  wire soft_rst  = byte_done & ~is_cmd & (state == epc_pkg::EPC_PANEL) & (param_idx == 3'h0)
                   & ~byte_in[`EPC_BIT_SOFT_RST]; // [R1]
  wire boost_now = panel1[`EPC_BIT_BOOST];
  wire boost_rise = boost_now & ~boost_q;
  // the device only listens; the data line is never driven
  assign sdata_o    = 1'b0; // [R20]
  assign sdata_oe_o = 1'b0; // [R20]
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      shift   <= 8'h00;
      bit_cnt <= 3'h0;
    end
    else if (!selected)
    begin
      bit_cnt <= 3'h0;
    end
    else if (sclk_rise)
    begin
      shift   <= byte_in;
      bit_cnt <= bit_cnt + 3'h1;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state     <= epc_pkg::EPC_IDLE;
      param_idx <= 3'h0;
      panel1    <= `EPC_PANEL1_RST; // [R23]
      panel2    <= `EPC_PANEL2_RST; // [R23]
      for (int i = 0; i < 6; i++)
        supply_source_select[i] <= (i == 0) ? `EPC_POWER1_RST : `EPC_POWER_RST; // [R23]
      floated   <= 1'b1;
    end
    else if (pin_reset || soft_rst)
    begin
      state     <= epc_pkg::EPC_IDLE;
      param_idx <= 3'h0;
      panel1    <= `EPC_PANEL1_RST; // [R1]
      panel2    <= `EPC_PANEL2_RST; // [R1]
      for (int i = 0; i < 6; i++)
        supply_source_select[i] <= (i == 0) ? `EPC_POWER1_RST : `EPC_POWER_RST; // [R1]
      floated   <= 1'b1; // [R1]
    end
    else if (byte_done)
    begin
      if (is_cmd)
      begin
        param_idx <= 3'h0; // [R22]
        if (byte_in == `EPC_CMD_PANEL)
          state <= epc_pkg::EPC_PANEL;
        else if (byte_in == `EPC_CMD_POWER)
          state <= epc_pkg::EPC_POWER;
        else
          state <= epc_pkg::EPC_IGNORE;
      end
      else
      begin
        case (state)
          epc_pkg::EPC_PANEL:
          begin
            if (param_idx == 3'h0)
            begin
              panel1  <= byte_in;
              floated <= 1'b0;
            end
            else if (param_idx == 3'h1)
              panel2 <= byte_in;
          end
          epc_pkg::EPC_POWER:
          begin
            if (param_idx < 3'h6)
              supply_source_select[param_idx] <= byte_in; // [R22]
          end
          default:
          begin
          end
        endcase
        if (param_idx != 3'h7)
          param_idx <= param_idx + 3'h1; // [R22]
      end
    end
  end
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rstp_q  <= 1'b0;
      boost_q <= 1'b0;
      temp_measure_o <= 1'b0;
      byte_valid_o   <= 1'b0;
    end
    else
    begin
      rstp_q  <= rstp_s[1];
      boost_q <= boost_now;
      // one measurement pulse, at pin release or at booster start
      temp_measure_o <= panel2[`EPC_BIT_AUTO_TEMP_TRIGGER] ? pin_rise : boost_rise; // [R10]
      byte_valid_o   <= byte_done;
    end
  end
  // codes whose low 7 bits exceed 78h are saturated, bit 7 is dropped; the analog side sees 15 V
  function automatic logic [6:0] epc_clip(input logic [7:0] code);
    epc_clip = (code[6:0] > `EPC_CODE_MAX) ? `EPC_CODE_MAX : code[6:0];
  endfunction : epc_clip

  assign next_panel.booster_on             = boost_now; // [R2]
  assign next_panel.source_shift_dir       = panel1[`EPC_BIT_SHIFT]; // [R3]
  assign next_panel.gate_scan_dir          = panel1[`EPC_BIT_SCAN]; // [R4]
  assign next_panel.power_switch_timing    = panel1[`EPC_BIT_PST]; // [R5]
  assign next_panel.resolution_select      = panel1[`EPC_BIT_RES_LO +: 2]; // [R6]
  assign next_panel.float_after_refresh    = panel2[`EPC_BIT_FLOAT_REF]; // [R7]
  assign next_panel.ground_tie_before_off  = panel2[`EPC_BIT_GND_TIE]; // [R8]
  assign next_panel.neg_gate_ground_tie    = panel2[`EPC_BIT_VGN_TIE]; // [R9]
  assign next_panel.auto_temp_trigger      = panel2[`EPC_BIT_AUTO_TEMP_TRIGGER]; // [R10]
  assign next_panel.electrode_always_float = panel2[`EPC_BIT_ALW_FLOAT]; // [R11]
  assign next_panel.power_off_float_opt    = panel2[`EPC_BIT_POFF_FLT]; // [R12]
  assign next_panel.waveform_table_source  = panel2[`EPC_BIT_LUT_SRC]; // [R13]

  assign next_power.internal_gate_supply_en   = supply_source_select[0][0]; // [R15]
  assign next_power.internal_source_supply_en = supply_source_select[0][1]; // [R15]
  assign next_power.internal_low_source_en    = supply_source_select[0][2]; // [R15]
  assign next_power.source_mode               = supply_source_select[0][`EPC_BIT_MODE]; // [R16]
  assign next_power.gate_level_code           = supply_source_select[1][1:0]; // [R17]
  assign next_power.low_source_code_m0        = epc_clip(supply_source_select[2]); // [R18]
  assign next_power.high_source_code_m1       = epc_clip(supply_source_select[3]); // [R18]
  assign next_power.neg_source_code_m1        = epc_clip(supply_source_select[4]); // [R19]
  assign next_power.low_source_code_m1        = epc_clip(supply_source_select[5]); // [R18]

  // highest-priority electrode option wins
  assign next_com = panel2[`EPC_BIT_ALW_FLOAT] ? epc_pkg::EPC_COM_FLOAT :
                    panel2[`EPC_BIT_GND_TIE]   ? epc_pkg::EPC_COM_GROUND :
                    panel2[`EPC_BIT_POFF_FLT]  ? epc_pkg::EPC_COM_POFF_FLOAT :
                    panel2[`EPC_BIT_FLOAT_REF] ? epc_pkg::EPC_COM_FLOAT :
                                                 epc_pkg::EPC_COM_DRIVE; // [R14]

  // outputs are registered so the panel side never sees decode glitches;
  // the cost is one more cycle between the last bit and the new setting
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      panel_o    <= epc_pkg::epc_panel_t'(`EPC_PANEL_OUT_RST); // [R23]
      power_o    <= epc_pkg::epc_power_t'(`EPC_POWER_OUT_RST); // [R23]
      com_mode_o <= epc_pkg::epc_com_t'(`EPC_COM_OUT_RST); // [R23]
    end
    else
    begin
      panel_o    <= next_panel;
      power_o    <= next_power;
      com_mode_o <= next_com;
    end
  end

  assign float_outputs_o = floated; // [R1]
endmodule : epc_config

//--- rtl/epc_defs.svh
`ifndef EPC_DEFS_SVH
`define EPC_DEFS_SVH
`define EPC_CMD_PANEL      8'h00
`define EPC_CMD_POWER      8'h01
`define EPC_PANEL1_RST     8'h0f
`define EPC_PANEL2_RST     8'h09
`define EPC_POWER1_RST     8'h07
`define EPC_POWER_RST      8'h00
`define EPC_BIT_SOFT_RST   0
`define EPC_BIT_BOOST      1
`define EPC_BIT_SHIFT      2
`define EPC_BIT_SCAN       3
`define EPC_BIT_PST        5
`define EPC_BIT_RES_LO     6
`define EPC_BIT_FLOAT_REF  0
`define EPC_BIT_GND_TIE    1
`define EPC_BIT_VGN_TIE    2
`define EPC_BIT_AUTO_TEMP_TRIGGER    3
`define EPC_BIT_ALW_FLOAT  4
`define EPC_BIT_POFF_FLT   5
`define EPC_BIT_LUT_SRC    7
`define EPC_BIT_MODE       3
`define EPC_CODE_MAX       7'h78
`define EPC_PANEL_OUT_RST  13'h1c48
`define EPC_POWER_OUT_RST  34'h3_8000_0000
`define EPC_COM_OUT_RST    2'h1
`endif

//--- rtl/epc_pkg.sv
package epc_pkg;
  typedef enum logic [1:0] {
    EPC_IDLE = 2'b00,
    EPC_PANEL = 2'b01,
    EPC_POWER = 2'b11,
    EPC_IGNORE = 2'b10
  } epc_state_t;
  typedef enum logic [1:0] {
    EPC_COM_DRIVE = 2'b00,
    EPC_COM_FLOAT = 2'b01,
    EPC_COM_GROUND = 2'b10,
    EPC_COM_POFF_FLOAT = 2'b11
  } epc_com_t;
  typedef struct packed {
    logic       booster_on;
    logic       source_shift_dir;
    logic       gate_scan_dir;
    logic       power_switch_timing;
    logic [1:0] resolution_select;
    logic       float_after_refresh;
    logic       ground_tie_before_off;
    logic       neg_gate_ground_tie;
    logic       auto_temp_trigger;
    logic       electrode_always_float;
    logic       power_off_float_opt;
    logic       waveform_table_source;
  } epc_panel_t;
  typedef struct packed {
    logic       internal_gate_supply_en;
    logic       internal_source_supply_en;
    logic       internal_low_source_en;
    logic       source_mode;
    logic [1:0] gate_level_code;
    logic [6:0] low_source_code_m0;
    logic [6:0] high_source_code_m1;
    logic [6:0] neg_source_code_m1;
    logic [6:0] low_source_code_m1;
  } epc_power_t;
endpackage : epc_pkg

//--- sim/epc_config_monitor.sv
`timescale 1ns/1ps
module epc_config_monitor (
  input wire logic           clk_i,
  input wire logic           rst_i,
  input wire logic           rst_n_pin_i,
  input wire logic           sdata_o,
  input wire logic           sdata_oe_o,
  input epc_pkg::epc_panel_t panel_o,
  input epc_pkg::epc_power_t power_o,
  input epc_pkg::epc_com_t   com_mode_o,
  input wire logic           float_outputs_o,
  input wire logic           temp_measure_o,
  input wire logic           byte_valid_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_slave; !sdata_oe_o && !sdata_o; endproperty
  a_slave: assert property (p_slave) else $error("port drove data");
  property p_vld; byte_valid_o |=> !byte_valid_o; endproperty
  a_vld: assert property (p_vld) else $error("byte pulse too long");
  property p_tmp; temp_measure_o |=> !temp_measure_o; endproperty
  a_tmp: assert property (p_tmp) else $error("temp pulse too long");
  property p_pin;
    !rst_n_pin_i [*4] |=> panel_o == 13'h1c48 && power_o == 34'h3_8000_0000 && float_outputs_o;
  endproperty
  a_pin: assert property (p_pin) else $error("pin reset lost defaults");
  property p_clip; power_o.neg_source_code_m1 <= 7'h78 && power_o.low_source_code_m0 <= 7'h78; endproperty
  a_clip: assert property (p_clip) else $error("code above limit");
  // com mode is registered in the same cycle as the fields; only settled fields are judged
  property p_electrode_always_float; panel_o.electrode_always_float && $stable(panel_o) |-> com_mode_o == 2'd1; endproperty
  a_electrode_always_float: assert property (p_electrode_always_float) else $error("always float ignored");
  property p_gnd;
    !panel_o.electrode_always_float && panel_o.ground_tie_before_off && $stable(panel_o) |-> com_mode_o == 2'd2;
  endproperty
  a_gnd: assert property (p_gnd) else $error("ground tie ignored");
  property p_poff;
    {panel_o.electrode_always_float, panel_o.ground_tie_before_off, panel_o.power_off_float_opt} == 3'b001
      && $stable(panel_o) |-> com_mode_o == 2'd3;
  endproperty
  a_poff: assert property (p_poff) else $error("power off float ignored");
  property p_far;
    {panel_o.electrode_always_float, panel_o.ground_tie_before_off, panel_o.power_off_float_opt} == 3'b000
      && $stable(panel_o) |-> com_mode_o == {1'b0, panel_o.float_after_refresh};
  endproperty
  a_far: assert property (p_far) else $error("float after refresh wrong");
endmodule : epc_config_monitor
bind epc_config epc_config_monitor u_mon (.clk_i, .rst_i, .rst_n_pin_i, .sdata_o, .sdata_oe_o, .panel_o,
  .power_o, .com_mode_o, .float_outputs_o, .temp_measure_o, .byte_valid_o);

//--- sim/epc_host_model.sv
`timescale 1ns/1ps
module epc_host_model (
  input  wire logic clk_i,
  output logic      sclk_o,
  output logic      csb_n_o,
  output logic      dc_o,
  output logic      sdata_o
);
  initial
  begin
    sclk_o = 1'b0;
    csb_n_o = 1'b1;
    dc_o = 1'b1;
    sdata_o = 1'b0;
  end
  task automatic half();
    repeat (5) @(negedge clk_i);
  endtask : half
  // bits move only while sclk is low, so each is steady around the rising edge
  task automatic xfer(input logic dc, input logic [7:0] b);
    csb_n_o = 1'b0;
    dc_o = dc;
    for (int i = 7; i >= 0; i--)
    begin
      sdata_o = b[i];
      half();
      sclk_o = 1'b1;
      half();
      sclk_o = 1'b0;
    end
  endtask : xfer
  task automatic close();
    half();
    csb_n_o = 1'b1;
    sdata_o = ~sdata_o;
    half();
  endtask : close
endmodule : epc_host_model

//--- sim/tb_epd_panel_power_config.sv
`timescale 1ns/1ps
module tb_epd_panel_power_config;
  logic                clk_i = 1'b0;
  logic                rst_i = 1'b1;
  logic                pin_n = 1'b1;
  logic                sclk, csb_n, dc, sd, flt;
  epc_pkg::epc_panel_t panel;
  epc_pkg::epc_power_t power;
  epc_pkg::epc_com_t   com;
  int                  err_count = 0;
  int                  checked = 0;
  int                  cyc = 0;
  logic [7:0]          p [8];
  logic                tmp, vld;
  int                  tmp_cnt = 0;
  int                  vld_cnt = 0;
  int                  exp_tmp = 1;
  logic                boost_prev = 1'b1;
  logic                ts_prev = 1'b1;
  always #4 clk_i = ~clk_i;
  epc_host_model u_host (.clk_i(clk_i), .sclk_o(sclk), .csb_n_o(csb_n), .dc_o(dc), .sdata_o(sd));
  epc_config dut_u (.clk_i(clk_i), .rst_i(rst_i), .rst_n_pin_i(pin_n), .sclk_i(sclk), .csb_n_i(csb_n),
    .cmd_data_select_i(dc), .sdata_i(sd), .sdata_o(), .sdata_oe_o(), .panel_o(panel), .power_o(power),
    .com_mode_o(com), .float_outputs_o(flt), .temp_measure_o(tmp), .byte_valid_o(vld));
  function automatic logic [6:0] clip(logic [7:0] v);
    return (v[6:0] > 7'h78) ? 7'h78 : v[6:0];
  endfunction : clip
  function automatic logic [33:0] exp_power();
    return {p[0][0], p[0][1], p[0][2], p[0][3], p[1][1:0], clip(p[2]), clip(p[3]), clip(p[4]), clip(p[5])};
  endfunction : exp_power
  task automatic chk(input logic [33:0] got, input logic [33:0] want);
    checked++;
    if (got !== want)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, want);
    end
  endtask : chk
  task automatic test_done();
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic chk_dflt();
    chk(panel, 13'h1c48);
    chk(power, 34'h3_8000_0000);
    chk({flt, com}, 3'b101);
  endtask : chk_dflt
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (tmp === 1'b1) tmp_cnt <= tmp_cnt + 1;
    if (vld === 1'b1) vld_cnt <= vld_cnt + 1;
    if (cyc == 40000)
    begin
      err_count++;
      test_done();
    end
  end
  initial
  begin
    void'($urandom(45));
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    chk_dflt();
    for (int n = 0; n < 24; n++)
    begin
      for (int k = 0; k < 8; k++) p[k] = 8'($urandom);
      // codes straddling the 78h ceiling first
      if (n < 4) for (int k = 2; k < 6; k++) p[k] = (n == 3) ? 8'hff : 8'h77 + 8'(n);
      p[6][0] = 1'b1;
      // booster start measures only when the trigger bit already held 0
      if (!ts_prev && !boost_prev && p[6][1]) exp_tmp++;
      boost_prev = p[6][1];
      ts_prev = p[7][3];
      u_host.xfer(1'b0, 8'h00);
      u_host.xfer(1'b1, p[6]);
      u_host.xfer(1'b1, p[7]);
      u_host.close();
      u_host.xfer(1'b0, 8'h01);
      for (int k = 0; k < 7; k++) u_host.xfer(1'b1, p[k]);
      u_host.close();
      u_host.xfer(1'b0, 8'h02);
      u_host.xfer(1'b1, p[7]);
      u_host.close();
      chk(panel, {p[6][1], p[6][2], p[6][3], p[6][5], p[6][7:6], p[7][0], p[7][1], p[7][2], p[7][3], p[7][4],
        p[7][5], p[7][7]});
      chk({flt, com}, {1'b0, p[7][4] ? 2'd1 : p[7][1] ? 2'd2 : p[7][5] ? 2'd3 : {1'b0, p[7][0]}});
      chk(power, exp_power());
    end
    u_host.xfer(1'b0, 8'h00);
    u_host.xfer(1'b1, 8'hfe);
    u_host.close();
    chk_dflt();
    u_host.xfer(1'b0, 8'h01);
    u_host.xfer(1'b1, 8'h08);
    u_host.close();
    pin_n = 1'b0;
    repeat (6) @(negedge clk_i);
    pin_n = 1'b1;
    repeat (4) @(negedge clk_i);
    chk_dflt();
    repeat (4) @(negedge clk_i);
    chk(34'(tmp_cnt), 34'(exp_tmp + 1));
    chk(34'(vld_cnt), 34'd316);
    test_done();
  end
endmodule : tb_epd_panel_power_config
